// file: hdl/sarcv_top.sv
// Control of an 8-bit successive-approximation converter with serial readout.
// Assumes start pin and serial clock come from a host in another domain.
//
// Overview of operation
// - Result is straight binary, one code step per reference over 256.
// - Starts powered down; start pin rising edge powers up over 1.5 us.
// - Start pin falling edge moves track to hold and starts converting.
// - Conversion lasts 4 us typical, 5 max; then latch result, sample pin.
// - Pin high at conversion end keeps the converter powered.
// - Pin low at conversion end powers down after latching.
// - Early falling edge waits out power-up; never convert unpowered.
// - Serial port enabled only by a start pin rising edge.
// - Read before conversion end gives previous result, after gives current.
// - Result load into shift register waits for a read in progress.
// - Start rising edge resets bit counter; clocks after a full word start the next read.
// - Data bits change on serial clock rising edges, first after enable.
// - Eighth falling serial edge floats output and resets the counter.
// - Serial clock may be continuous or come in bursts.
// - Serial port works while the converter is powered down.
`timescale 1ns/1ps

module sarcv_top
  import sarcv_pkg::*;
#(
  parameter int PWRUP_CYC = `SARCV_PWRUP_CYC,
  parameter int CONV_CYC = `SARCV_CONV_CYC,
  parameter int FIFO_DEPTH = `SARCV_FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic conversion_start_n,
  input wire logic sclk,
  output logic dout_o,
  output logic dout_oe,
  input wire logic [`SARCV_RES_BITS-1:0] sample_code,
  output logic sample_hold,
  output logic powered,
  output logic busy
);

  initial begin
    if (PWRUP_CYC < 1 || CONV_CYC < 1 || CONV_CYC > 4095 || PWRUP_CYC > 4095) begin
      $error("sarcv_top: timing counts out of range");
    end
  end

  // ----------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------
  logic cs_meta_q;
  logic cs_sync_q;
  logic cs_prev_q;
  logic ck_meta_q;
  logic ck_sync_q;
  logic ck_prev_q;
  logic cs_rise;
  logic cs_fall;
  logic ck_rise;
  logic ck_fall;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cs_meta_q <= 1'b0;
      cs_sync_q <= 1'b0;
      cs_prev_q <= 1'b0;
      ck_meta_q <= 1'b0;
      ck_sync_q <= 1'b0;
      ck_prev_q <= 1'b0;
    end else begin
      cs_meta_q <= conversion_start_n;
      cs_sync_q <= cs_meta_q;
      cs_prev_q <= cs_sync_q;
      ck_meta_q <= sclk;
      ck_sync_q <= ck_meta_q;
      ck_prev_q <= ck_sync_q;
    end
  end

  assign cs_rise = cs_sync_q && !cs_prev_q;
  assign cs_fall = !cs_sync_q && cs_prev_q;
  // Edges are found by sampling, so bursts and free-running clocks look alike
  assign ck_rise = ck_sync_q && !ck_prev_q;
  assign ck_fall = !ck_sync_q && ck_prev_q;

  // ----------------------------------------
  // Converter sequencer
  // ----------------------------------------
  sarcv_state_e state_q;
  sarcv_state_e state_d;
  logic [11:0] cnt_q;
  logic pend_q;
  logic conv_done;
  logic pwrup_end;
  logic wake_start;
  logic conv_start;
  sarcv_result_s res_in;
  logic fifo_in_ready;

  assign conv_done = (state_q == SARCV_CONV) && (cnt_q == 12'(CONV_CYC - 1)) && fifo_in_ready;
  assign pwrup_end = (state_q == SARCV_WAKE) && (cnt_q == 12'(PWRUP_CYC - 1));
  assign wake_start = (state_q == SARCV_OFF) && cs_rise;
  // Early fall is remembered and served once power-up ends
  assign conv_start = (pwrup_end && (pend_q || cs_fall))
                      || ((state_q == SARCV_TRACK) && cs_fall);

  always_comb begin
    state_d = state_q;
    case (state_q)
      SARCV_OFF: begin
        if (wake_start) begin
          state_d = SARCV_WAKE;
        end
      end
      SARCV_WAKE: begin
        if (pwrup_end) begin
          state_d = conv_start ? SARCV_CONV : SARCV_TRACK;
        end
      end
      SARCV_TRACK: begin
        if (conv_start) begin
          state_d = SARCV_CONV;
        end
      end
      SARCV_CONV: begin
        if (conv_done) begin
          // Pin level at the end picks the mode
          state_d = cs_sync_q ? SARCV_TRACK : SARCV_OFF;
        end
      end
      default: begin
        state_d = SARCV_OFF;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= SARCV_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend_q <= 1'b0;
    end else if (state_q != SARCV_WAKE) begin
      pend_q <= 1'b0;
    end else if (cs_fall) begin
      pend_q <= 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if ((state_q == SARCV_WAKE && cnt_q == 12'(PWRUP_CYC - 1))
                 || (state_q == SARCV_TRACK && cs_fall) || conv_done
                 || state_q == SARCV_OFF) begin
      cnt_q <= '0;
    end else if (state_q == SARCV_WAKE || state_q == SARCV_CONV) begin
      // Holds at the end count while the result queue is full
      if (!(state_q == SARCV_CONV && cnt_q == 12'(CONV_CYC - 1))) begin
        cnt_q <= cnt_q + 12'h001;
      end
    end
  end

  // Held sample captured at the hold instant; code is straight binary
  logic [`SARCV_RES_BITS-1:0] held_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      held_q <= `SARCV_RES_RST;
    end else if (state_q != SARCV_CONV) begin
      held_q <= sample_code;
    end
  end

  assign res_in.code = held_q;
  assign res_in.keep_power = cs_sync_q;

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  // Hold and busy rise with the state change, so they span the whole conversion
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sample_hold <= 1'b0;
    end else begin
      sample_hold <= conv_start || ((state_q == SARCV_CONV) && !conv_done);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= conv_start || ((state_q == SARCV_CONV) && !conv_done);
    end
  end

  // Up from the waking edge, so the whole power-up spell shows as powered
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      powered <= 1'b0;
    end else begin
      powered <= wake_start
                 || ((state_q != SARCV_OFF) && !(conv_done && !cs_sync_q));
    end
  end

  // ----------------------------------------
  // Result queue between converter and readout
  // ----------------------------------------
  sarcv_result_s res_out;
  logic res_valid;
  logic res_take;

  sarcv_fifo #(
    .WIDTH($bits(sarcv_result_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_data(res_in),
    .in_valid(conv_done),
    .in_ready(fifo_in_ready),
    .out_data(res_out),
    .out_valid(res_valid),
    .out_ready(res_take)
  );

  // ----------------------------------------
  // Serial readout
  // ----------------------------------------
  logic port_en_q;
  logic [3:0] bits_q;
  logic reading;
  logic shift_en;

  // A read is in progress from the first shifted bit to the eighth fall
  assign reading = port_en_q && bits_q != 4'h0;
  // Oldest queued result enters the shift register only between reads
  assign res_take = res_valid && !reading;
  assign shift_en = port_en_q && ck_rise && bits_q < 4'h8 && !res_take;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      port_en_q <= 1'b0;
    end else if (cs_rise) begin
      // Stays armed after a word; the counter alone re-arms the next read
      port_en_q <= 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bits_q <= 4'h0;
    end else if (cs_rise) begin
      bits_q <= 4'h0;
    end else if (port_en_q && ck_fall && bits_q == 4'h8) begin
      bits_q <= 4'h0;
    end else if (shift_en) begin
      bits_q <= bits_q + 4'h1;
    end
  end

  // Serial side never looks at the power state
  sarcv_shift #(
    .BITS(`SARCV_RES_BITS)
  ) u_shift (
    .clock(clock),
    .rst(rst),
    .load(res_take),
    .load_data(res_out.code),
    .shift(shift_en),
    .bit_out(dout_o)
  );

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dout_oe <= 1'b0;
    end else if (cs_rise || (port_en_q && ck_fall && bits_q == 4'h8)) begin
      dout_oe <= 1'b0;
    end else if (shift_en) begin
      dout_oe <= 1'b1;
    end
  end

endmodule

// file: hdl/sarcv_params.svh
// Constants of the converter control and serial readout block.
// Assumes a 40 MHz core clock; included by bare name.
`ifndef SARCV_PARAMS_SVH
`define SARCV_PARAMS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define SARCV_CLK_PERIOD_PS 25000
`define SARCV_PWRUP_NS 1500
`define SARCV_CONV_MAX_NS 5000
`define SARCV_CONV_TYP_NS 4000
// Least times round up
`define SARCV_PWRUP_CYC ((`SARCV_PWRUP_NS * 1000 + `SARCV_CLK_PERIOD_PS - 1) / `SARCV_CLK_PERIOD_PS)
`define SARCV_CONV_CYC ((`SARCV_CONV_TYP_NS * 1000 + `SARCV_CLK_PERIOD_PS - 1) / `SARCV_CLK_PERIOD_PS)

// ----------------------------------------
// Word layout
// ----------------------------------------
`define SARCV_RES_BITS 8
`define SARCV_CODE_STEPS 256
`define SARCV_FIFO_DEPTH 32
`define SARCV_RES_RST 8'h00

`endif

// file: hdl/sarcv_pkg.sv
// Types of the converter control and serial readout block.
// Assumes sarcv_params.svh is on the include path.
`include "sarcv_params.svh"

package sarcv_pkg;

  typedef logic [`SARCV_RES_BITS-1:0] sarcv_code_t;

  // Converter sequencer states, one-hot
  typedef enum logic [3:0] {
    SARCV_OFF   = 4'b0001,
    SARCV_WAKE  = 4'b0010,
    SARCV_TRACK = 4'b0100,
    SARCV_CONV  = 4'b1000
  } sarcv_state_e;

  // A finished conversion as it travels to the readout side
  typedef struct packed {
    sarcv_code_t code;
    logic keep_power;
  } sarcv_result_s;

endpackage

// file: hdl/sarcv_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock domain; depth a power of two.
`timescale 1ns/1ps

module sarcv_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("sarcv_fifo: bad WIDTH or DEPTH");
    end
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
    end else if (push) begin
      wr_q <= wr_q + (AW+1)'(1);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_q <= '0;
    end else if (pop) begin
      rd_q <= rd_q + (AW+1)'(1);
    end
  end

endmodule

// file: hdl/sarcv_shift.sv
// Eight-bit output shift register with load and shift strobes.
// Assumes strobes come from logic on the same clock.
`timescale 1ns/1ps

module sarcv_shift
  import sarcv_pkg::*;
#(
  parameter int BITS = `SARCV_RES_BITS
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic load,
  input wire logic [BITS-1:0] load_data,
  input wire logic shift,
  output logic bit_out
);

  initial begin
    if (BITS != `SARCV_RES_BITS) begin
      $error("sarcv_shift: width must match result");
    end
  end

  logic [BITS-1:0] sr_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sr_q <= '0;
      bit_out <= 1'b0;
    end else if (load) begin
      sr_q <= load_data;
    end else if (shift) begin
      bit_out <= sr_q[BITS-1];
      sr_q <= {sr_q[BITS-2:0], 1'b0};
    end
  end

endmodule

// file: test/sarcv_top_assertions.sv
// Port checker of the converter control and serial readout block.
// Assumes a bind to sarcv_top; both pins arrive unsynchronised.
`timescale 1ns/1ps
`include "sarcv_params.svh"
module sarcv_top_assertions #(
  parameter int PWRUP_CYC = 60,
  parameter int CONV_CYC = 160
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic conversion_start_n,
  input wire logic sclk,
  input wire logic dout_o,
  input wire logic dout_oe,
  input wire logic [`SARCV_RES_BITS-1:0] sample_code,
  input wire logic sample_hold,
  input wire logic powered,
  input wire logic busy
);
  logic [5:0] sh_q;
  logic [5:0] ch_q;
  logic [8:0] busy_cnt_q;
  logic [8:0] pw_cnt_q;
  logic seen_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sh_q <= 6'h00;
      ch_q <= 6'h00;
      seen_q <= 1'b0;
    end else begin
      sh_q <= {sh_q[4:0], sclk};
      ch_q <= {ch_q[4:0], conversion_start_n};
      seen_q <= seen_q | (ch_q[0] & ~ch_q[1]);
    end
  end
  // Power count saturates, so a long powered spell cannot wrap
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_cnt_q <= 9'h000;
      pw_cnt_q <= 9'h000;
    end else begin
      busy_cnt_q <= busy ? busy_cnt_q + 9'h001 : 9'h000;
      pw_cnt_q <= !powered ? 9'h000 : pw_cnt_q + {8'h00, pw_cnt_q != 9'h1ff};
    end
  end
  sequence s_conv_end;
    $fell(busy);
  endsequence
  sequence s_kept_up;
    powered [*3];
  endsequence
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_hold_is_busy: assert property (sample_hold == busy)
    else $error("hold and busy differ");
  a_conv_when_powered: assert property (busy |-> powered)
    else $error("conversion while unpowered");
  a_pwrup_elapsed: assert property ($rose(busy) |-> pw_cnt_q >= PWRUP_CYC)
    else $error("conversion before power-up time");
  a_conv_length: assert property (s_conv_end |-> busy_cnt_q == CONV_CYC)
    else $error("conversion length wrong");
  a_auto_down: assert property (s_conv_end ##0 (ch_q == 6'h00) |-> ##[0:3] !powered)
    else $error("no power-down with pin low");
  a_stay_up: assert property (s_conv_end ##0 (ch_q == 6'h3f) |-> s_kept_up)
    else $error("powered down with pin high");
  a_port_gated: assert property (dout_oe |-> seen_q)
    else $error("output driven before start rise");
  a_data_steady: assert property (dout_oe && $past(dout_oe) && sh_q == 6'h00 |-> $stable(dout_o))
    else $error("data moved without clock rise");
  a_float_on_fall: assert property ($fell(dout_oe) && ch_q inside {6'h00, 6'h3f} |-> !$past(sclk, 2))
    else $error("output released off a clock fall");
endmodule

bind sarcv_top sarcv_top_assertions #(.PWRUP_CYC(PWRUP_CYC), .CONV_CYC(CONV_CYC)) u_chk (
  .clock(clock), .rst(rst), .conversion_start_n(conversion_start_n), .sclk(sclk),
  .dout_o(dout_o), .dout_oe(dout_oe), .sample_code(sample_code),
  .sample_hold(sample_hold), .powered(powered), .busy(busy));

// file: test/sarcv_host.sv
// Host model: drives the start pin and the serial clock, reads data.
// Assumes the bench resolves the data line from the output enable.
`timescale 1ns/1ps
module sarcv_host (
  input wire logic clock,
  input wire logic dout_line,
  output logic conversion_start_n,
  output logic sclk
);
  initial begin
    conversion_start_n = 1'b0;
    sclk = 1'b0;
  end
  // Start pin doubles as this device's select on a shared bus
  task set_cs(input logic v);
    @(negedge clock);
    conversion_start_n = v;
  endtask
  // Data moves on the rise, so it is taken just before the fall
  task read8(input int gap, output logic [7:0] word);
    for (int i = 7; i >= 0; i--) begin
      repeat (4) @(negedge clock);
      sclk = 1'b1;
      repeat (4) @(negedge clock);
      word[i] = dout_line;
      sclk = 1'b0;
      repeat (gap) @(negedge clock);
    end
    repeat (8) @(negedge clock);
  endtask
endmodule

// file: test/tb_sarcv_top.sv
// Self-checking bench of the converter control and serial readout block.
// Assumes the host model and checker are compiled alongside.
`timescale 1ns/1ps
module tb_sarcv_top;
  import sarcv_pkg::*;
  localparam int PW = 4;
  localparam int CV = 40;
  logic clock, rst, conversion_start_n, sclk, dout_o, dout_oe;
  logic sample_hold, powered, busy;
  sarcv_code_t sample_code;
  logic [7:0] word;
  wire dout_pin;
  int failures = 0;
  int checks = 0;
  // No pull on the data line: a released line reads as z
  assign dout_pin = dout_oe ? dout_o : 1'bz;
  sarcv_top #(.PWRUP_CYC(PW), .CONV_CYC(CV)) u_sarcv_top (
    .clock(clock), .rst(rst), .conversion_start_n(conversion_start_n), .sclk(sclk),
    .dout_o(dout_o), .dout_oe(dout_oe), .sample_code(sample_code),
    .sample_hold(sample_hold), .powered(powered), .busy(busy));
  sarcv_host u_sarcv_host (.clock(clock), .dout_line(dout_pin),
    .conversion_start_n(conversion_start_n), .sclk(sclk));
  task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task end_sim();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task wait_for(input string what, input bit on_busy, input logic val);
    int n;
    n = 0;
    while ((on_busy ? busy : powered) !== val && n < 500) begin
      @(negedge clock);
      n++;
    end
    if ((on_busy ? busy : powered) !== val) begin
      chk(what, 8'h00, 8'h01);
      end_sim();
    end
  endtask
  task t_auto_power_down();
    u_sarcv_host.read8(0, word);
    chk("idle port", word, 8'hzz);
    chk("off at start", {7'h00, powered}, 8'h00);
    sample_code = 8'ha5;
    u_sarcv_host.set_cs(1'b1);
    u_sarcv_host.set_cs(1'b0);
    wait_for("busy rise", 1'b1, 1'b1);
    sample_code = 8'h00;
    wait_for("busy fall", 1'b1, 1'b0);
    wait_for("power down", 1'b0, 1'b0);
    u_sarcv_host.read8(0, word);
    chk("read after down", word, 8'ha5);
    chk("float", {7'h00, dout_oe}, 8'h00);
  endtask
  task t_high_speed();
    sample_code = 8'h3c;
    u_sarcv_host.set_cs(1'b1);
    wait_for("power up", 1'b0, 1'b1);
    repeat (PW + 4) @(negedge clock);
    u_sarcv_host.set_cs(1'b0);
    wait_for("busy rise", 1'b1, 1'b1);
    repeat (2) @(negedge clock);
    u_sarcv_host.set_cs(1'b1);
    wait_for("busy fall", 1'b1, 1'b0);
    repeat (6) @(negedge clock);
    chk("kept powered", {7'h00, powered}, 8'h01);
    sample_code = 8'hc3;
    u_sarcv_host.set_cs(1'b0);
    repeat (2) @(negedge clock);
    u_sarcv_host.set_cs(1'b1);
    u_sarcv_host.read8(0, word);
    chk("read across end", word, 8'h3c);
    u_sarcv_host.read8(12, word);
    chk("burst read", word, 8'hc3);
  endtask
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    rst = 1'b1;
    sample_code = 8'h00;
    repeat (3) @(negedge clock);
    rst = 1'b0;
    repeat (3) @(negedge clock);
    t_auto_power_down();
    t_high_speed();
    end_sim();
  end
endmodule
